/* File: inc/gs_sink_cfg.svh */
`ifndef GS_SINK_CFG_SVH
`define GS_SINK_CFG_SVH

`define GS_CHANNELS        24
`define GS_BITS            12
`define GS_SHIFT_BITS      288
`define GS_PERIOD_COUNTS   4096
`define GS_COUNT_MAX       12'hfff
`define GS_COUNT_RESET     12'h000
`define GS_CLK_PERIOD_PS   4000
`define GS_LATCH_GAP_NS    100
`define GS_LATCH_GAP_CYC   ((`GS_LATCH_GAP_NS * 1000 + `GS_CLK_PERIOD_PS - 1) / `GS_CLK_PERIOD_PS)

`endif

/* File: inc/gs_sink_pkg.sv */
package gs_sink_pkg;
    typedef logic [11:0] gray_t;
    typedef logic [287:0] frame_t;
    typedef enum logic [2:0] {
        ST_BLANKED = 3'b001,
        ST_RUN     = 3'b010,
        ST_HOLDOFF = 3'b100
    } pwm_state_e;
    typedef struct packed {
        logic   valid;
        frame_t data;
    } frame_word_s;
endpackage

/* File: logic/gs_frame_buffer.sv */
`timescale 1ns/1ps
module gs_frame_buffer
    import gs_sink_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // fill side
    input  wire logic   in_valid,
    input  wire frame_t in_data,
    output logic        in_ready,
    // drain side
    output logic        out_valid,
    input  wire logic   out_ready,
    output frame_t      out_data
);
    typedef struct packed {
        frame_t [1:0] mem;
        logic         rd;
        logic         wr;
        logic [1:0]   count;
    } fb_s;

    fb_s st_reg;
    fb_s st_next;

    assign in_ready  = (st_reg.count != 2'h2);
    assign out_valid = (st_reg.count != 2'h0);
    assign out_data  = st_reg.mem[st_reg.rd];

    always_comb begin
        logic push;
        logic pop;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = ~st_reg.wr;
        end
        if (pop) begin
            st_next.rd = ~st_reg.rd;
        end
        st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

/* File: logic/gs_pwm_sink.sv */
`timescale 1ns/1ps
`include "gs_sink_cfg.svh"
module gs_pwm_sink
    import gs_sink_pkg::*;
(
    // core oscillator domain
    input  wire logic                  clk,
    input  wire logic                  rst,
    // serial link domain
    input  wire logic                  shift_clk,
    input  wire logic                  serial_gray_in,
    output logic                       cascade_serial_out,
    // control pins
    input  wire logic                  latch_strobe,
    input  wire logic                  blank,
    // sink outputs, high means current on
    output logic [`GS_CHANNELS-1:0]    sink_output,
    // buffer back-pressure seen by the latch path
    output logic                       latch_ready
);
    // link side state, shift_clk domain
    frame_t shift_reg;
    logic   cascade_reg;

    always_ff @(posedge shift_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= {shift_reg[`GS_SHIFT_BITS-2:0], serial_gray_in};
        end
    end

    always_ff @(negedge shift_clk or posedge rst) begin
        if (rst) begin
            cascade_reg <= 1'b0;
        end else begin
            cascade_reg <= shift_reg[`GS_SHIFT_BITS-1];
        end
    end

    assign cascade_serial_out = cascade_reg;

    // core state
    typedef struct packed {
        logic [2:0]      latch_sync;
        logic            latch_level;
        logic [2:0]      blank_sync;
        logic            blank_level;
        logic            capture_pend;
        pwm_state_e      state;
        gray_t           counter;
        frame_t          display;
        logic [`GS_CHANNELS-1:0] outs;
    } core_s;

    core_s  st_reg;
    core_s  st_next;
    logic   buf_in_valid;
    logic   buf_out_valid;
    frame_t buf_out_data;

    // the host keeps shift_reg still for 100 ns after the latch rise, so a
    // wide sample four to five clocks later is stable without a handshake
    assign buf_in_valid = st_reg.capture_pend;

    gs_frame_buffer u_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (buf_in_valid),
        .in_data   (shift_reg),
        .in_ready  (latch_ready),
        .out_valid (buf_out_valid),
        .out_ready (1'b1),
        .out_data  (buf_out_data)
    );

    function automatic gray_t chan_value(input frame_t f, input int idx);
        chan_value = f[idx*`GS_BITS +: `GS_BITS];
    endfunction

    always_comb begin
        logic latch_rise;
        latch_rise = 1'b0;
        st_next = st_reg;
        st_next.latch_sync = {st_reg.latch_sync[1:0], latch_strobe};
        st_next.blank_sync = {st_reg.blank_sync[1:0], blank};
        if (st_reg.latch_sync[2] == st_reg.latch_sync[1]) begin
            st_next.latch_level = st_reg.latch_sync[1];
        end
        if (st_reg.blank_sync[2] == st_reg.blank_sync[1]) begin
            st_next.blank_level = st_reg.blank_sync[1];
        end
        latch_rise = st_next.latch_level && !st_reg.latch_level;
        if (latch_rise) begin
            st_next.capture_pend = 1'b1;
        end else if (latch_ready) begin
            st_next.capture_pend = 1'b0;
        end
        if (buf_out_valid) begin
            st_next.display = buf_out_data;
        end
        st_next.counter = st_reg.counter + 12'h001;
        case (st_reg.state)
            ST_BLANKED: begin
                st_next.counter = `GS_COUNT_RESET;
                if (!st_reg.blank_level) begin
                    st_next.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (latch_rise) begin
                    st_next.state = ST_HOLDOFF;
                end
            end
            ST_HOLDOFF: begin
                if (st_reg.counter == `GS_COUNT_MAX) begin
                    st_next.state = ST_RUN;
                end
            end
            default: begin
                st_next.state = ST_BLANKED;
            end
        endcase
        if (st_reg.blank_level) begin
            st_next.state   = ST_BLANKED;
            st_next.counter = `GS_COUNT_RESET;
        end
        for (int i = 0; i < `GS_CHANNELS; i++) begin
            st_next.outs[i] = (st_next.state == ST_RUN) &&
                              (st_next.counter < chan_value(st_next.display, i));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg             <= '0;
            st_reg.state       <= ST_BLANKED;
            // blank idles as blanked out of reset so no false release is seen
            st_reg.blank_sync  <= 3'h7;
            st_reg.blank_level <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sink_output = st_reg.outs;
endmodule

/* File: test/gs_host_model.sv */
`timescale 1ns/1ps
module gs_host_model
    import gs_sink_pkg::*;
(
    // link pins
    output logic shift_clk,
    output logic serial_gray_in,
    output logic latch_strobe
);
    initial {shift_clk, serial_gray_in, latch_strobe} = 3'h0;
    // clock idles low between frames; data flips so a stale bit never looks valid
    task automatic send(input frame_t f);
        #1.7;
        for (int i = 287; i >= 0; i--) begin
            serial_gray_in = f[i];
            #3 shift_clk = 1'b1;
            #3 shift_clk = 1'b0;
        end
        serial_gray_in = ~serial_gray_in;
        latch_strobe = 1'b1;
        #20 latch_strobe = 1'b0;
        #100;
    endtask
endmodule

/* File: test/gs_pwm_sink_sva.sv */
`timescale 1ns/1ps
module gs_pwm_sink_sva (
    // core domain
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        latch_strobe,
    input wire logic        blank,
    input wire logic [23:0] sink_output,
    // link domain
    input wire logic        shift_clk,
    input wire logic        serial_gray_in,
    input wire logic        cascade_serial_out
);
    int   sc;
    int   per;
    logic seen;
    logic pok;
    always_ff @(posedge shift_clk or posedge rst) begin
        if (rst) sc <= 0;
        else if (sc < 300) sc <= sc + 1;
    end
    // period only timed when no latch or blank could move the phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {seen, pok} <= 2'h0;
            per <= 0;
        end else begin
            seen <= seen | latch_strobe;
            per <= $rose(sink_output[0]) ? 1 : per + 1;
            pok <= !(blank | latch_strobe) && (pok | $rose(sink_output[0]));
        end
    end
    property p_shift; @(posedge shift_clk) disable iff (rst) sc > 289 |-> cascade_serial_out == $past(serial_gray_in, 288); endproperty
    a_shift: assert property (p_shift) else $error("shift order");
    property p_casc; @(negedge shift_clk) disable iff (rst) sc > 289 |-> cascade_serial_out == $past(serial_gray_in, 288); endproperty
    a_casc: assert property (p_casc) else $error("cascade edge");
    property p_nolat; @(posedge clk) disable iff (rst) !seen |-> sink_output == '0; endproperty
    a_nolat: assert property (p_nolat) else $error("lit before latch");
    property p_hold; @(posedge clk) disable iff (rst) $rose(latch_strobe) |-> ##[3:8] sink_output == '0; endproperty
    a_hold: assert property (p_hold) else $error("no hold-off");
    property p_brise; @(posedge clk) disable iff (rst) $rose(blank) |-> ##[1:6] sink_output == '0; endproperty
    a_brise: assert property (p_brise) else $error("blank slow");
    property p_blank; @(posedge clk) disable iff (rst) blank [*8] |-> sink_output == '0; endproperty
    a_blank: assert property (p_blank) else $error("lit in blank");
    property p_tog; @(posedge clk) disable iff (rst) (sink_output & ~$past(sink_output)) != '0 |-> $past(sink_output) == '0; endproperty
    a_tog: assert property (p_tog) else $error("late turn-on");
    property p_per; @(posedge clk) disable iff (rst) $rose(sink_output[0]) && pok |-> per == 4096; endproperty
    a_per: assert property (p_per) else $error("period");
endmodule
bind gs_pwm_sink gs_pwm_sink_sva i_sva (.clk, .rst, .latch_strobe, .blank, .sink_output, .shift_clk,
    .serial_gray_in, .cascade_serial_out);

/* File: test/serial_grayscale_pwm_led_sink_tb.sv */
`timescale 1ns/1ps
module serial_grayscale_pwm_led_sink_tb;
    import gs_sink_pkg::*;
    logic        clk, rst, blank, shift_clk, serial_gray_in, latch_strobe, cascade_serial_out, latch_ready;
    logic [23:0] sink_output;
    int          num_errors, checked, cyc;
    gs_pwm_sink i_dut (.clk, .rst, .shift_clk, .serial_gray_in, .cascade_serial_out, .latch_strobe,
        .blank, .sink_output, .latch_ready);
    gs_host_model i_host (.shift_clk, .serial_gray_in, .latch_strobe);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // waits for channel 0 to turn on, bounded by 9000 clocks, just over two periods
    task automatic rise();
        int n;
        n = 0;
        while (sink_output[0] !== 1'b0 && n < 9000) begin
            @(negedge clk) n++;
        end
        while (sink_output[0] !== 1'b1 && n < 9000) begin
            @(negedge clk) n++;
        end
        chk(n < 9000, 1);
    endtask
    task automatic frame(input gray_t v0, input gray_t v23);
        int h0, h23;
        {h0, h23} = 0;
        i_host.send({v23, 264'h0, v0});
        chk(cascade_serial_out, v23[11]);
        rise();
        repeat (4096) begin
            h0 += sink_output[0];
            h23 += sink_output[23];
            @(negedge clk);
        end
        chk({h23[15:0], h0[15:0]}, {4'h0, v23, 4'h0, v0});
    endtask
    task automatic blank_run();
        int t0;
        rise();
        chk(latch_ready, 1);
        repeat (100) @(negedge clk);
        blank = 1'b1;
        repeat (8) @(negedge clk);
        chk(sink_output, 0);
        blank = 1'b0;
        t0 = cyc;
        rise();
        chk(cyc - t0 < 10, 1);
    endtask
    task automatic latch_run();
        int t0;
        rise();
        t0 = cyc;
        repeat (1000) @(negedge clk);
        i_host.send({12'h000, 264'h0, 12'hfff});
        chk(sink_output, 0);
        rise();
        chk(cyc - t0, 4096);
    endtask
    initial begin
        {num_errors, checked, cyc} = 0;
        rst = 1'b1;
        blank = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        blank = 1'b0;
        frame(12'h001, 12'hffe);
        frame(12'hfff, 12'h000);
        frame(12'h010, 12'h7ff);
        blank_run();
        latch_run();
        summarize();
    end
    initial begin
        #400000;
        num_errors++;
        summarize();
    end
endmodule
